//--- hdl/fpsc_top.sv
/*
 * Front panel serial controller core: three-wire link, command execution,
 * key scanner, led output, and the lcd driver instance.
 * Assumes the master holds load high for at least four system clocks between
 * frames and keeps data setup to the link clock rising edge.
 */
// Functional notes
// - link uses three wires: serial clock, two-way data and load strobe.
// - every bit moves at a rising link clock edge in both directions.
// - load rising edge executes the shifted command, except at the end of a read frame, and clears serial output state.
// - while load is high, link clock edges are ignored entirely.
// - scan-complete rises once the scan started by a key command finishes.
// - after key data is read, next load rise drops scan-complete.
// - scan-complete stays low from reset until a scan completes.
// - led level follows the led bit of the first display word.
// - led is active-low open drain: pulled low to light, else released.
// - led stays released after reset until display data arrives.
// - lcd drives up to 75 segments as 25 segment lines by 3 commons.
// - segment and common activity together select the lit segments.
// - 1/3 duty, 1/3 bias, frame repeats at 325.5 Hz.
// - key scanner reads 30 keys as 5 sources by 6 returns.
// - five open-drain key source outputs drive the matrix.
// - six return inputs with pull-downs sense pressed keys.
// - blank input switches the lcd display on and off; the led output is not blanked.
`timescale 1ns/1ns
module fpsc_top #(
    parameter int PHASE_CYC = fpsc_pkg::PHASE_CYC_DEF,
    parameter int HOLD_CYC  = fpsc_pkg::SRC_HOLD_DEF
) (
    // system
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    // three-wire link
    input  wire logic                                link_clk,
    input  wire logic                                link_load,
    input  wire logic                                link_data_in,
    output logic                                     link_data_out,
    output logic                                     link_data_oe,
    output logic                                     scan_done,
    // led, open drain
    output logic                                     led_out,
    output logic                                     led_oe,
    // key matrix
    output logic [fpsc_pkg::N_SRC-1:0]               key_source_out,
    output logic [fpsc_pkg::N_SRC-1:0]               key_source_oe,
    input  wire logic [fpsc_pkg::N_RET-1:0]          key_return,
    // lcd
    input  wire logic                                blank,
    output fpsc_pkg::fpsc_lvl_t [fpsc_pkg::N_COM-1:0] lcd_common,
    output fpsc_pkg::fpsc_lvl_t [fpsc_pkg::N_SEG-1:0] segment_out
);
    import fpsc_pkg::*;

    localparam int HW = $clog2(HOLD_CYC + 1);

    // link domain
    logic [CMD_W-1:0]     cmd_shift_reg;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic                 tx_bit_reg;
    logic                 tx_oe_reg;

    // system domain
    logic                            load_meta_reg;
    logic                            load_sync_reg;
    logic                            load_prev_reg;
    logic                            load_rise;
    logic                            exec;
    logic [1:0]                      op;
    logic                            key_mode_reg;
    logic                            scan_done_reg;
    logic                            led_oe_reg;
    logic                            led_out_reg;
    logic [N_COM-1:0][N_SEG-1:0]     seg_reg;
    logic [N_KEY-1:0]                key_reg;
    logic [N_RET-1:0]                ret_meta_reg;
    logic [N_RET-1:0]                ret_sync_reg;
    fpsc_scan_e                      scan_st_reg;
    logic [2:0]                      src_idx_reg;
    logic [HW-1:0]                   hold_cnt_reg;
    logic [N_SRC-1:0]                ks_oe_reg;
    logic [N_SRC-1:0]                ks_out_reg;
    logic                            scan_start;
    logic                            sample;
    logic                            scan_fin;

    // ---- link clock domain ----

    // load is read raw here: it is the frame's own gate and is static around
    // every link clock edge that the master issues
    always_ff @(posedge link_clk) begin
        if (!link_load) begin
            cmd_shift_reg <= {cmd_shift_reg[CMD_W-2:0], link_data_in};
        end
    end

    // load high holds the output side cleared, so no edge can shift out
    always_ff @(posedge link_clk or posedge link_load) begin
        if (link_load) begin
            bit_cnt_reg <= '0;
            tx_bit_reg  <= 1'b0;
            tx_oe_reg   <= 1'b0;
        end else begin
            if (bit_cnt_reg != BIT_CNT_MAX) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h1;
            end
            // key_mode_reg and key_reg only change while load is high or
            // before scan_done rises, so they are static during a read frame
            tx_oe_reg <= key_mode_reg;
            if (key_mode_reg && bit_cnt_reg < 6'(N_KEY)) begin
                tx_bit_reg <= key_reg[bit_cnt_reg[4:0]];
            end else begin
                tx_bit_reg <= 1'b0;
            end
        end
    end

    assign link_data_out = tx_bit_reg;
    assign link_data_oe  = tx_oe_reg;

    // ---- system clock domain ----

    // load is pulled up, so the synchroniser rests high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            load_meta_reg <= LOAD_IDLE;
            load_sync_reg <= LOAD_IDLE;
            load_prev_reg <= LOAD_IDLE;
        end else begin
            load_meta_reg <= link_load;
            load_sync_reg <= load_meta_reg;
            load_prev_reg <= load_sync_reg;
        end
    end

    assign load_rise = load_sync_reg & ~load_prev_reg;
    // the shift register is frozen while load is high, so reading it here is safe
    assign op        = cmd_shift_reg[OP_HI:OP_LO];
    // a read frame fills the shifter with the device's own bits; never execute those
    assign exec      = load_rise & ~key_mode_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            key_mode_reg <= 1'b0;
        end else if (load_rise) begin
            key_mode_reg <= !key_mode_reg && (op == OP_KEY_OUT);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seg_reg <= '0;
        end else if (exec && op != OP_KEY_OUT) begin
            seg_reg[op] <= cmd_shift_reg[N_SEG-1:0];
        end
    end

    // led bit 1 means lit: pull the line low; 0 releases it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            led_oe_reg  <= 1'b0;
            led_out_reg <= 1'b0;
        end else if (exec && op == OP_DISP_A) begin
            led_oe_reg <= cmd_shift_reg[LED_BIT];
        end
    end

    assign led_oe  = led_oe_reg;
    assign led_out = led_out_reg;

    // ---- key scanner ----

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ret_meta_reg <= '0;
            ret_sync_reg <= '0;
        end else begin
            ret_meta_reg <= key_return;
            ret_sync_reg <= ret_meta_reg;
        end
    end

    assign scan_start = exec && (op == OP_KEY_OUT);
    assign sample     = (scan_st_reg == SC_DRIVE) && (hold_cnt_reg == HW'(HOLD_CYC - 1));
    assign scan_fin   = sample && (src_idx_reg == 3'(N_SRC - 1));

    // a new key command restarts a scan already running
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scan_st_reg  <= SC_IDLE;
            src_idx_reg  <= 3'h0;
            hold_cnt_reg <= '0;
        end else begin
            case (scan_st_reg)
                SC_IDLE: begin
                    if (scan_start) begin
                        scan_st_reg  <= SC_DRIVE;
                        src_idx_reg  <= 3'h0;
                        hold_cnt_reg <= '0;
                    end
                end
                SC_DRIVE: begin
                    if (scan_start) begin
                        src_idx_reg  <= 3'h0;
                        hold_cnt_reg <= '0;
                    end else if (scan_fin) begin
                        scan_st_reg <= SC_IDLE;
                    end else if (sample) begin
                        src_idx_reg  <= src_idx_reg + 3'h1;
                        hold_cnt_reg <= '0;
                    end else begin
                        hold_cnt_reg <= hold_cnt_reg + 1'b1;
                    end
                end
                default: begin
                    scan_st_reg <= SC_IDLE;
                end
            endcase
        end
    end

    // keys hold their last sampled state until the next scan
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            key_reg <= '0;
        end else if (sample && !scan_start) begin
            key_reg[src_idx_reg * N_RET +: N_RET] <= ret_sync_reg;
        end
    end

    // idle sources pull low; the active one is released and pulled high outside
    for (genvar i = 0; i < N_SRC; i++) begin : g_src
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                ks_oe_reg[i]  <= 1'b1;
                ks_out_reg[i] <= 1'b0;
            end else begin
                ks_oe_reg[i] <= !(scan_st_reg == SC_DRIVE && src_idx_reg == 3'(i));
            end
        end
    end

    assign key_source_oe  = ks_oe_reg;
    assign key_source_out = ks_out_reg;

    // completion beats a same-cycle clear so a finished scan is never lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scan_done_reg <= 1'b0;
        end else if (scan_fin) begin
            scan_done_reg <= 1'b1;
        end else if ((load_rise && key_mode_reg) || scan_start) begin
            scan_done_reg <= 1'b0;
        end
    end

    assign scan_done = scan_done_reg;

    // ---- lcd ----

    fpsc_lcd_if lcd_bus ();

    assign lcd_bus.seg_data = seg_reg;
    assign lcd_bus.blank    = blank;
    assign lcd_common       = lcd_bus.com_lvl;
    assign segment_out      = lcd_bus.seg_lvl;

    fpsc_lcd #(
        .PHASE_CYC (PHASE_CYC)
    ) u_lcd (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (lcd_bus)
    );

    // ---- checks ----

    property p_scan_bound;
        @(posedge clk) disable iff (!rst_n)
        scan_start |-> ##[1:600] scan_done_reg;
    endproperty
    a_scan_bound: assert property (p_scan_bound) else $error("scan did not complete in time");

    property p_scan_clear;
        @(posedge clk) disable iff (!rst_n)
        (load_rise && key_mode_reg && !scan_fin) |=> !scan_done_reg;
    endproperty
    a_scan_clear: assert property (p_scan_clear) else $error("scan_done not dropped on load");

    property p_scan_cause;
        @(posedge clk) disable iff (!rst_n)
        $rose(scan_done_reg) |-> $past(scan_st_reg == SC_DRIVE && src_idx_reg == 3'(N_SRC - 1));
    endproperty
    a_scan_cause: assert property (p_scan_cause) else $error("scan_done rose without a scan");

    property p_led_follow;
        @(posedge clk) disable iff (!rst_n)
        (exec && op == OP_DISP_A) |=> (led_oe_reg == $past(cmd_shift_reg[LED_BIT])) && !led_out_reg;
    endproperty
    a_led_follow: assert property (p_led_follow) else $error("led does not follow led bit");

    property p_led_float;
        @(posedge clk) disable iff (!rst_n)
        $rose(led_oe_reg) |-> $past(exec && op == OP_DISP_A);
    endproperty
    a_led_float: assert property (p_led_float) else $error("led driven without display data");

    property p_one_source;
        @(posedge clk) disable iff (!rst_n)
        (scan_st_reg == SC_DRIVE && !scan_start) |=> $onehot(~ks_oe_reg) && $onehot0(~ks_oe_reg);
    endproperty
    a_one_source: assert property (p_one_source) else $error("not exactly one source active");

    property p_exec_store;
        @(posedge clk) disable iff (!rst_n)
        (exec && op != OP_KEY_OUT) |=> seg_reg[$past(op)] == $past(cmd_shift_reg[N_SEG-1:0]);
    endproperty
    a_exec_store: assert property (p_exec_store) else $error("display word not stored");

    property p_link_quiet;
        @(posedge link_clk) disable iff (link_load)
        !key_mode_reg |=> !tx_oe_reg && !tx_bit_reg;
    endproperty
    a_link_quiet: assert property (p_link_quiet) else $error("data driven outside read frame");
endmodule

//--- hdl/fpsc_pkg.sv
/*
 * Shared constants and types of the front panel serial controller.
 * Assumes a 25 MHz system clock; all counts derive from CLK_HZ.
 */
package fpsc_pkg;
    // clock
    localparam int CLK_HZ        = 25_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

    // geometry
    localparam int N_COM = 3;
    localparam int N_SEG = 25;
    localparam int N_SRC = 5;
    localparam int N_RET = 6;
    localparam int N_KEY = N_SRC * N_RET;

    // command word, msb first on the link
    localparam int CMD_W   = 32;
    localparam int OP_HI   = 31;
    localparam int OP_LO   = 30;
    localparam int LED_BIT = 25;
    localparam logic [1:0] OP_DISP_A  = 2'h0;
    localparam logic [1:0] OP_DISP_B  = 2'h1;
    localparam logic [1:0] OP_DISP_C  = 2'h2;
    localparam logic [1:0] OP_KEY_OUT = 2'h3;

    // link bit counter
    localparam int         BIT_CNT_W   = 6;
    localparam logic [5:0] BIT_CNT_MAX = 6'h3f;

    // lcd frame: 325.5 Hz, three common phases per frame
    localparam longint FRAME_MILLIHZ = 325500;
    localparam int     PHASE_CYC_DEF =
        int'((longint'(CLK_HZ) * 1000) / (FRAME_MILLIHZ * N_COM));

    // key source settle time before the returns are sampled (least time)
    localparam int SRC_SETTLE_NS = 4000;
    localparam int SRC_HOLD_DEF  = (SRC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // drive levels of the 1/3 bias ladder
    typedef logic [1:0] fpsc_lvl_t;
    localparam fpsc_lvl_t LV0 = 2'h0;
    localparam fpsc_lvl_t LV1 = 2'h1;
    localparam fpsc_lvl_t LV2 = 2'h2;
    localparam fpsc_lvl_t LV3 = 2'h3;

    // reset values
    localparam logic LOAD_IDLE = 1'b1;

    typedef enum logic {SC_IDLE, SC_DRIVE} fpsc_scan_e;
endpackage

//--- hdl/fpsc_lcd_if.sv
/*
 * Carrier between the controller core and the lcd driver.
 * Assumes both ends sit on the system clock.
 */
`timescale 1ns/1ns
interface fpsc_lcd_if;
    logic [fpsc_pkg::N_COM-1:0][fpsc_pkg::N_SEG-1:0] seg_data;
    logic                                            blank;
    fpsc_pkg::fpsc_lvl_t [fpsc_pkg::N_COM-1:0]       com_lvl;
    fpsc_pkg::fpsc_lvl_t [fpsc_pkg::N_SEG-1:0]       seg_lvl;

    modport ctrl (output seg_data, output blank, input com_lvl, input seg_lvl);
    modport drv  (input seg_data, input blank, output com_lvl, output seg_lvl);
endinterface

//--- hdl/fpsc_lcd.sv
/*
 * LCD driver: 1/3 duty, 1/3 bias multiplex of 25 segments on 3 commons.
 * Assumes levels are 2-bit ladder codes resolved by an external analog stage;
 * the blank input is asynchronous and is synchronised here.
 */
`timescale 1ns/1ns
module fpsc_lcd #(
    parameter int PHASE_CYC = fpsc_pkg::PHASE_CYC_DEF
) (
    // system
    input wire logic clk,
    input wire logic rst_n,
    // core side
    fpsc_lcd_if.drv  bus
);
    import fpsc_pkg::*;

    localparam int PW = $clog2(PHASE_CYC);

    logic [PW-1:0] ph_cnt_reg;
    logic [1:0]    com_sel_reg;
    logic          inv_reg;
    logic          blank_meta_reg;
    logic          blank_sync_reg;
    logic          tick;

    assign tick = (ph_cnt_reg == PW'(PHASE_CYC - 1));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            blank_meta_reg <= 1'b0;
            blank_sync_reg <= 1'b0;
        end else begin
            blank_meta_reg <= bus.blank;
            blank_sync_reg <= blank_meta_reg;
        end
    end

    // timing runs from the system clock only, never the link clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph_cnt_reg <= '0;
        end else begin
            ph_cnt_reg <= tick ? '0 : ph_cnt_reg + 1'b1;
        end
    end

    // three phases per frame; polarity flips each frame to keep dc off the glass
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            com_sel_reg <= 2'h0;
            inv_reg     <= 1'b0;
        end else if (tick) begin
            com_sel_reg <= (com_sel_reg == 2'(N_COM - 1)) ? 2'h0 : com_sel_reg + 2'h1;
            if (com_sel_reg == 2'(N_COM - 1)) begin
                inv_reg <= ~inv_reg;
            end
        end
    end

    for (genvar c = 0; c < N_COM; c++) begin : g_com
        always_ff @(posedge clk) begin
            if (!rst_n || blank_sync_reg) begin
                bus.com_lvl[c] <= LV0;
            end else if (com_sel_reg == 2'(c)) begin
                bus.com_lvl[c] <= inv_reg ? LV0 : LV3;
            end else begin
                bus.com_lvl[c] <= inv_reg ? LV2 : LV1;
            end
        end
    end

    // lit segment sits at the far rail from the selected common
    for (genvar s = 0; s < N_SEG; s++) begin : g_seg
        always_ff @(posedge clk) begin
            if (!rst_n || blank_sync_reg) begin
                bus.seg_lvl[s] <= LV0;
            end else if (bus.seg_data[com_sel_reg][s]) begin
                bus.seg_lvl[s] <= inv_reg ? LV3 : LV0;
            end else begin
                bus.seg_lvl[s] <= inv_reg ? LV1 : LV2;
            end
        end
    end

    property p_blank_dark;
        @(posedge clk) disable iff (!rst_n)
        blank_sync_reg |=> (bus.com_lvl == '0) && (bus.seg_lvl == '0);
    endproperty
    a_blank_dark: assert property (p_blank_dark) else $error("panel not dark while blanked");

    property p_frame_step;
        @(posedge clk) disable iff (!rst_n)
        (tick && com_sel_reg == 2'h2) |=> (com_sel_reg == 2'h0) && (inv_reg != $past(inv_reg));
    endproperty
    a_frame_step: assert property (p_frame_step) else $error("frame did not wrap and invert");

    property p_com_select;
        @(posedge clk) disable iff (!rst_n)
        (!blank_sync_reg && !tick && com_sel_reg == 2'h1) |=>
            (bus.com_lvl[1] == LV0 || bus.com_lvl[1] == LV3) && (bus.com_lvl[0] != bus.com_lvl[1]);
    endproperty
    a_com_select: assert property (p_com_select) else $error("selected common not at rail");
endmodule

//--- tb/fpsc_master.sv
/*
 * Master microcontroller model on the far side of the three-wire link.
 * Assumes frames start from idle with load high; the link clock runs inside frames, and also with load high in idle_pulses.
 */
`timescale 1ns/1ns
module fpsc_master (
    // system
    input  wire logic clk,
    // three-wire link
    output logic      link_clk,
    output logic      link_load,
    output logic      link_data,
    input  wire logic dev_data,
    input  wire logic dev_oe
);
    logic mst_data;
    logic mst_oe;
    logic last_level;

    // no pull on data: a released line shows the inverse of its last level
    assign link_data = dev_oe ? dev_data : (mst_oe ? mst_data : ~last_level);

    always @* begin
        if (dev_oe)
            last_level = dev_data;
        else if (mst_oe)
            last_level = mst_data;
    end

    // load starts low for 1 ns: its power-on rise clears the device's link output side
    initial begin
        link_clk   = 1'b0;
        link_load  = 1'b0;
        mst_data   = 1'b0;
        mst_oe     = 1'b0;
        last_level = 1'b0;
        #1 link_load = 1'b1;
    end

    // one frame of 32 bits, msb first, data moved after each falling edge
    task automatic send_word(input logic [31:0] w);
        @(negedge clk);
        link_load = 1'b0;
        mst_oe    = 1'b1;
        for (int i = 31; i >= 0; i--) begin
            mst_data = w[i];
            #3 link_clk = 1'b1;
            #3 link_clk = 1'b0;
        end
        @(negedge clk);
        link_load = 1'b1;
        mst_oe    = 1'b0;
        repeat (6) @(negedge clk); // idle gap well over 4 clk
    endtask

    // read frame: bit k is taken just ahead of rising edge k+2
    task automatic read_word(output logic [29:0] k);
        @(negedge clk);
        link_load = 1'b0;
        #3 link_clk = 1'b1;
        #3 link_clk = 1'b0;
        // sampled just ahead of the edge, before that edge launches the next bit
        for (int i = 0; i < 30; i++) begin
            #3 k[i] = link_data;
            link_clk = 1'b1;
            #3 link_clk = 1'b0;
        end
        @(negedge clk);
        link_load = 1'b1;
        repeat (6) @(negedge clk);
    endtask

    // clock edges while load is high must have no effect
    task automatic idle_pulses(input int n);
        mst_oe   = 1'b1;
        mst_data = 1'b1;
        repeat (n) begin
            #3 link_clk = 1'b1;
            #3 link_clk = 1'b0;
        end
        mst_oe = 1'b0;
    endtask
endmodule

//--- tb/tb_top.sv
/*
 * Self-checking bench of the front panel serial controller.
 * Assumes short lcd phase and key hold counts set by parameter.
 */
`timescale 1ns/1ns
module tb_top;
    import fpsc_pkg::*;
    localparam int PH = 8;
    localparam int HD = 4;

    logic                           clk;
    logic                           rst_n;
    logic                           link_clk;
    logic                           link_load;
    logic                           link_data;
    logic                           data_out;
    logic                           data_oe;
    logic                           scan_done;
    logic                           led_out;
    logic                           led_oe;
    logic [N_SRC-1:0]               src_out;
    logic [N_SRC-1:0]               src_oe;
    logic [N_RET-1:0]               key_return;
    logic                           blank;
    fpsc_lvl_t [N_COM-1:0]          lcd_common;
    fpsc_lvl_t [N_SEG-1:0]          segment_out;
    logic [N_KEY-1:0]               pressed;
    int                             num_errors;
    int                             num_checks;

    fpsc_top #(.PHASE_CYC(PH), .HOLD_CYC(HD)) dut (
        .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .link_load(link_load),
        .link_data_in(link_data), .link_data_out(data_out), .link_data_oe(data_oe),
        .scan_done(scan_done), .led_out(led_out), .led_oe(led_oe),
        .key_source_out(src_out), .key_source_oe(src_oe), .key_return(key_return),
        .blank(blank), .lcd_common(lcd_common), .segment_out(segment_out));

    fpsc_master m (
        .clk(clk), .link_clk(link_clk), .link_load(link_load), .link_data(link_data),
        .dev_data(data_out), .dev_oe(data_oe));

    // key matrix: the released source feeds its pressed keys, pull-downs elsewhere
    always @* begin
        key_return = '0;
        for (int s = 0; s < N_SRC; s++)
            if (src_oe[s] === 1'b0)
                key_return |= pressed[s*N_RET +: N_RET];
    end

    always #20 clk = ~clk;

    always @(negedge clk) begin
        if (rst_n && $countones(~src_oe) > 1) begin
            num_errors++;
            $display("wrong value at %0t: two key sources active", $time);
        end
    end

    task automatic chk1(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chkv(input logic [63:0] got, input logic [63:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic t_reset();
        chk1(scan_done, 1'b0, "scan_done");
        chk1(led_oe, 1'b0, "led released");
        chkv(64'(src_oe), 64'h1f, "sources idle");
        chkv(64'(src_out), 64'h0, "sources low");
        chk1(data_oe, 1'b0, "data released");
    endtask

    task automatic t_led();
        m.send_word({OP_DISP_A, 4'h0, 1'b1, 25'h0});
        chk1(led_oe, 1'b1, "led lit");
        chk1(led_out, 1'b0, "led low");
        m.idle_pulses(8);
        chk1(data_oe, 1'b0, "oe during idle");
        m.send_word({OP_DISP_A, 30'h0});
        chk1(led_oe, 1'b0, "led off");
        m.send_word({OP_DISP_B, 4'h0, 1'b1, 25'h0}); // only the first word holds the led
        chk1(led_oe, 1'b0, "led kept off");
    endtask

    task automatic t_lcd();
        logic [N_SEG-1:0] pat [N_COM];
        fpsc_lvl_t        e;
        int               sel;
        int               prev;
        int               chg;
        int               flips;
        logic             inv;
        logic             pinv;
        logic             ok;
        pat[0] = 25'h1000001;
        pat[1] = 25'h0aaaaaa;
        pat[2] = 25'h0555555;
        for (int c = 0; c < N_COM; c++)
            m.send_word({2'(c), 5'h0, pat[c]});
        chg   = 0;
        flips = 0;
        for (int n = 0; n < 49; n++) begin
            @(posedge clk);
            #1;
            sel = 0;
            for (int c = 0; c < N_COM; c++)
                if (lcd_common[c] === LV3 || lcd_common[c] === LV0)
                    sel = c;
            inv = (lcd_common[sel] === LV0);
            ok  = 1'b1;
            for (int c = 0; c < N_COM; c++)
                if (c != sel && lcd_common[c] !== (inv ? LV2 : LV1))
                    ok = 1'b0;
            for (int s = 0; s < N_SEG; s++) begin
                e = pat[sel][s] ? (inv ? LV3 : LV0) : (inv ? LV1 : LV2);
                if (segment_out[s] !== e)
                    ok = 1'b0;
            end
            chk1(ok, 1'b1, "lcd levels");
            if (n > 0 && sel != prev)
                chg++;
            if (n > 0 && inv != pinv)
                flips++;
            prev = sel;
            pinv = inv;
        end
        chkv(64'(chg), 64'h6, "phase changes");
        chkv(64'(flips), 64'h2, "frame flips");
        @(negedge clk);
        blank = 1'b1;
        repeat (5) @(negedge clk);
        chkv(64'({lcd_common, segment_out}), 64'h0, "blanked");
        blank = 1'b0;
        repeat (5) @(negedge clk);
        chk1(|lcd_common, 1'b1, "unblanked");
    endtask

    task automatic t_keys(input logic [N_KEY-1:0] p);
        logic [N_KEY-1:0] k;
        int               i;
        pressed = p;
        m.send_word({OP_KEY_OUT, 30'h0});
        chk1(scan_done, 1'b0, "scan running");
        for (i = 0; i < 1000 && scan_done !== 1'b1; i++)
            @(negedge clk);
        if (i == 1000) begin
            num_errors++;
            $display("wrong value at %0t: scan never finished", $time);
            tally_and_finish();
        end
        chk1(scan_done, 1'b1, "scan done");
        m.read_word(k);
        chkv(64'(k), 64'(p), "key data");
        chk1(scan_done, 1'b0, "done cleared");
        chk1(data_oe, 1'b0, "data released");
    endtask

    initial begin
        clk        = 1'b0;
        rst_n      = 1'b0;
        blank      = 1'b0;
        pressed    = '0;
        num_errors = 0;
        num_checks = 0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset();
        t_led();
        t_lcd();
        t_keys(30'h20000421);
        t_keys(30'h1fffffde);
        tally_and_finish();
    end
endmodule
